// file: core/logic_combiner.sv
// One two-input signal combiner with operand and operator selection.
// Assumes the signal vector never carries combiner results.
`timescale 1ns/10ps
module logic_combiner #(
  parameter int SIG_W = 64
) (
  input  wire logic             CORE_CLK,
  input  wire logic             NRST,
  input  wire logic [SIG_W-1:0] SIG_VEC,
  input  wire logic [5:0]       OPND1_SEL,
  input  wire logic [5:0]       OPND2_SEL,
  input  wire logic [1:0]       OPER_SEL,
  output logic                  RESULT
);

  // Operand selects are six bits wide, so all 64 codes must exist
  if (SIG_W < 64) begin : g_bad_width
    $error("SIG_W must cover all 64 signal codes");
  end

  // ==========================================================
  // Combine
  logic a, b, result_d, result_q;

  // Recomputed every cycle from the current operands
  always_comb begin
    a = SIG_VEC[OPND1_SEL];
    b = SIG_VEC[OPND2_SEL];
    case (OPER_SEL)
      outsig_pkg::OP_OR:  result_d = a | b;
      outsig_pkg::OP_XOR: result_d = a ^ b;
      default:            result_d = a & b;
    endcase
  end

  // Registered for a clean output
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      result_q <= 1'b0;
    end else begin
      result_q <= result_d;
    end
  end

  assign RESULT = result_q;

endmodule

// file: core/output_signal_logic.sv
// Output-signal logic: six combiners, status flags, terminal routing.
// Assumes inputs are synchronous to CORE_CLK; plain register port.
//
// Notes on behaviour
// [R1] Codes 33 to 38 route combiners one to six.
// [R2] Each combiner has own operands and operator.
// [R3] Operands 00 to 50, default 00, no combiner codes.
// [R4] Operator 00 AND, 01 OR, 02 XOR; default AND.
// [R5] No combiner result feeds a combiner.
// [R6] Results recomputed every cycle.
// [R7] Code 39 routes capacitor wear flag.
// [R8] Wear flags shown in life monitor view.
// [R9] Timeout only with Modbus RTU on RS485.
// [R10] Timeout flag holds until next data.
// [R11] Timeout 0.00 to 99.99 s, default 0.00.
// [R12] Code 40 routes fan flag at 75 percent or less.
// [R13] Fan control 01 keeps fan flag low.
// [R14] Code 41 routes run command present flag.
// [R15] Run flag ignores run source selector.
// [R16] Forward and reverse together force a stop.
// [R17] Code 42 routes heatsink overtemperature flag.
// [R18] Warning level 0 to 200 C, default 120.
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module output_signal_logic #(
  parameter int TICK_CYCLES = outsig_pkg::TICK_CYCLES
) (
  input  wire logic        CORE_CLK,
  input  wire logic        NRST,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  input  wire logic [63:0] SIG_IN,
  input  wire logic        CAP_LIFE_LOW,
  input  wire logic [7:0]  FAN_SPEED_PCT,
  input  wire logic        FAN_STOPPED,
  input  wire logic        FORWARD_COMMAND_INPUT,
  input  wire logic        REVERSE_COMMAND_INPUT,
  input  wire logic [7:0]  HEATSINK_TEMP,
  input  wire logic        RX_DATA_STROBE,
  output logic      [5:0]  TERMINAL_OUT,
  output logic             RUN_STOP,
  output logic             IRQ
);

  // ==========================================================
  // Parameter check
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least one");
  end

  // ==========================================================
  // Configuration registers
  logic [5:0]  opnd1_q [outsig_pkg::COMB_COUNT];
  logic [5:0]  opnd1_d [outsig_pkg::COMB_COUNT];
  logic [5:0]  opnd2_q [outsig_pkg::COMB_COUNT];
  logic [5:0]  opnd2_d [outsig_pkg::COMB_COUNT];
  logic [1:0]  oper_q  [outsig_pkg::COMB_COUNT];
  logic [1:0]  oper_d  [outsig_pkg::COMB_COUNT];
  logic [5:0]  term_q  [outsig_pkg::TERM_COUNT];
  logic [5:0]  term_d  [outsig_pkg::TERM_COUNT];
  logic [13:0] rx_timeout_interval_q, rx_timeout_interval_d;
  logic [7:0]  heatsink_warning_level_q, heatsink_warning_level_d;
  logic [1:0]  fan_control_setting_q, fan_control_setting_d;
  logic [1:0]  link_cfg_q, link_cfg_d;
  logic [4:0]  irq_en_q, irq_en_d;

  // Legal operand code: in range and not a combiner result
  function automatic logic opnd_ok(input logic [5:0] code);
    opnd_ok = (code <= outsig_pkg::CODE_MAX_OPND) &&
              !((code >= outsig_pkg::CODE_LOG_FIRST) &&
                (code <= outsig_pkg::CODE_LOG_LAST));
  endfunction

  // True when an address falls within a bank of six words
  function automatic logic in_bank(input logic [7:0] a,
                                   input logic [7:0] base);
    in_bank = (a >= base) && (a < base + 8'h06);
  endfunction

  // Write decode; illegal settings are refused, old value kept
  always_comb begin
    int i;
    i = 0;
    opnd1_d = opnd1_q;
    opnd2_d = opnd2_q;
    oper_d = oper_q;
    term_d = term_q;
    rx_timeout_interval_d = rx_timeout_interval_q;
    heatsink_warning_level_d = heatsink_warning_level_q;
    fan_control_setting_d = fan_control_setting_q;
    link_cfg_d = link_cfg_q;
    irq_en_d = irq_en_q;
    if (WR) begin
      i = int'(ADDR[2:0]);
      if (in_bank(ADDR, outsig_pkg::ADDR_OPND1_BASE) &&
          opnd_ok(WDATA[5:0]))
        opnd1_d[i] = WDATA[5:0]; // R2 R3 R5
      if (in_bank(ADDR, outsig_pkg::ADDR_OPND2_BASE) &&
          opnd_ok(WDATA[5:0]))
        opnd2_d[i] = WDATA[5:0]; // R2 R3 R5
      if (in_bank(ADDR, outsig_pkg::ADDR_OPER_BASE) &&
          WDATA[1:0] <= outsig_pkg::OP_XOR)
        oper_d[i] = WDATA[1:0]; // R4
      if (in_bank(ADDR, outsig_pkg::ADDR_TERM_BASE))
        term_d[i] = WDATA[5:0]; // R1
      if (ADDR == outsig_pkg::ADDR_RX_TIMEOUT &&
          WDATA[13:0] <= outsig_pkg::RX_TIMEOUT_MAX)
        rx_timeout_interval_d = WDATA[13:0]; // R11
      if (ADDR == outsig_pkg::ADDR_HS_WARN &&
          WDATA[7:0] <= outsig_pkg::HS_WARN_MAX)
        heatsink_warning_level_d = WDATA[7:0]; // R18
      if (ADDR == outsig_pkg::ADDR_FAN_CTRL)
        fan_control_setting_d = WDATA[1:0]; // R13
      if (ADDR == outsig_pkg::ADDR_LINK_CFG)
        link_cfg_d = WDATA[1:0]; // R9
      if (ADDR == outsig_pkg::ADDR_IRQ_EN)
        irq_en_d = WDATA[4:0];
    end
  end

  // Register the configuration
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      for (int k = 0; k < outsig_pkg::COMB_COUNT; k++) begin
        opnd1_q[k] <= outsig_pkg::RST_OPND;
        opnd2_q[k] <= outsig_pkg::RST_OPND;
        oper_q[k]  <= outsig_pkg::RST_OPER;
        term_q[k]  <= outsig_pkg::RST_TERM;
      end
      rx_timeout_interval_q    <= outsig_pkg::RST_RX_TIMEOUT;
      heatsink_warning_level_q <= outsig_pkg::RST_HS_WARN;
      fan_control_setting_q    <= 2'h0;
      link_cfg_q               <= 2'h0;
      irq_en_q                 <= 5'h00;
    end else begin
      opnd1_q                  <= opnd1_d;
      opnd2_q                  <= opnd2_d;
      oper_q                   <= oper_d;
      term_q                   <= term_d;
      rx_timeout_interval_q    <= rx_timeout_interval_d;
      heatsink_warning_level_q <= heatsink_warning_level_d;
      fan_control_setting_q    <= fan_control_setting_d;
      link_cfg_q               <= link_cfg_d;
      irq_en_q                 <= irq_en_d;
    end
  end

  // ==========================================================
  // Status flags
  logic        capacitor_wear_flag_q, capacitor_wear_flag_d;
  logic        fan_wear_flag_q, fan_wear_flag_d;
  logic        run_command_present_flag_q, run_command_present_flag_d;
  logic        heatsink_overtemp_flag_q, heatsink_overtemp_flag_d;
  logic        rx_timeout_flag_q, rx_timeout_flag_d;
  logic        run_stop_q, run_stop_d;
  logic [31:0] tick_cnt_q, tick_cnt_d;
  logic [13:0] idle_ticks_q, idle_ticks_d;
  logic        modbus_on;

  assign modbus_on = (link_cfg_q == outsig_pkg::LINK_MODBUS);

  // Flag conditions and the reception watchdog
  always_comb begin
    capacitor_wear_flag_d = CAP_LIFE_LOW; // R7
    // Quiet fan mode hides a stopped or slow fan
    fan_wear_flag_d = (fan_control_setting_q != outsig_pkg::FAN_CTRL_QUIET)
      && (FAN_SPEED_PCT <= 8'(outsig_pkg::FAN_LOW_PCT)); // R12 R13
    // Source-independent: both command inputs arrive already merged
    run_command_present_flag_d = FORWARD_COMMAND_INPUT ^
                                 REVERSE_COMMAND_INPUT; // R14 R15
    run_stop_d = FORWARD_COMMAND_INPUT & REVERSE_COMMAND_INPUT; // R16
    heatsink_overtemp_flag_d =
      HEATSINK_TEMP > heatsink_warning_level_q; // R17
    tick_cnt_d = tick_cnt_q;
    idle_ticks_d = idle_ticks_q;
    rx_timeout_flag_d = rx_timeout_flag_q;
    if (!modbus_on || RX_DATA_STROBE) begin
      tick_cnt_d = 32'h0000_0000;
      idle_ticks_d = 14'h0000;
      rx_timeout_flag_d = 1'b0; // R9 R10
    end else if (tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_d = 32'h0000_0000;
      if (idle_ticks_q != 14'h3FFF) begin
        idle_ticks_d = idle_ticks_q + 14'h0001;
      end
    end else begin
      tick_cnt_d = tick_cnt_q + 32'h0000_0001;
    end
    // Zero interval disables the watchdog
    if (modbus_on && !RX_DATA_STROBE &&
        rx_timeout_interval_q != 14'h0000 &&
        idle_ticks_q >= rx_timeout_interval_q) begin
      rx_timeout_flag_d = 1'b1; // R10
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      capacitor_wear_flag_q      <= 1'b0;
      fan_wear_flag_q            <= 1'b0;
      run_command_present_flag_q <= 1'b0;
      heatsink_overtemp_flag_q   <= 1'b0;
      rx_timeout_flag_q          <= 1'b0;
      run_stop_q                 <= 1'b0;
      tick_cnt_q                 <= 32'h0000_0000;
      idle_ticks_q               <= 14'h0000;
    end else begin
      capacitor_wear_flag_q      <= capacitor_wear_flag_d;
      fan_wear_flag_q            <= fan_wear_flag_d;
      run_command_present_flag_q <= run_command_present_flag_d;
      heatsink_overtemp_flag_q   <= heatsink_overtemp_flag_d;
      rx_timeout_flag_q          <= rx_timeout_flag_d;
      run_stop_q                 <= run_stop_d;
      tick_cnt_q                 <= tick_cnt_d;
      idle_ticks_q               <= idle_ticks_d;
    end
  end

  assign RUN_STOP = run_stop_q;

  // ==========================================================
  // Signal vector; combiner codes left zero so results never loop
  logic [63:0] sig_vec;
  logic [5:0]  comb_res;

  always_comb begin
    sig_vec = SIG_IN;
    sig_vec[outsig_pkg::CODE_LOG_LAST:outsig_pkg::CODE_LOG_FIRST] = 6'h00;
    sig_vec[outsig_pkg::CODE_CAP_WEAR] = capacitor_wear_flag_q;
    sig_vec[outsig_pkg::CODE_FAN_WEAR] = fan_wear_flag_q;
    sig_vec[outsig_pkg::CODE_RUN_CMD]  = run_command_present_flag_q;
    sig_vec[outsig_pkg::CODE_OVERTEMP] = heatsink_overtemp_flag_q;
    sig_vec[outsig_pkg::CODE_NET_ERR]  = rx_timeout_flag_q;
  end

  // Six independent combiners
  for (genvar g = 0; g < outsig_pkg::COMB_COUNT; g++) begin : g_comb
    logic_combiner #(
      .SIG_W (64)
    ) u_comb (
      .CORE_CLK  (CORE_CLK),
      .NRST      (NRST),
      .SIG_VEC   (sig_vec),
      .OPND1_SEL (opnd1_q[g]),
      .OPND2_SEL (opnd2_q[g]),
      .OPER_SEL  (oper_q[g]),
      .RESULT    (comb_res[g])
    ); // R2 R5 R6
  end

  // ==========================================================
  // Terminal routing
  logic [63:0] route_vec;
  logic [5:0]  term_out_d;
  logic [5:0]  term_out_q;

  always_comb begin
    route_vec = sig_vec;
    route_vec[outsig_pkg::CODE_LOG_LAST:outsig_pkg::CODE_LOG_FIRST] =
      comb_res; // R1
    for (int k = 0; k < outsig_pkg::TERM_COUNT; k++) begin
      term_out_d[k] = route_vec[term_q[k]]; // R7 R12 R14 R17
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      term_out_q <= 6'h00;
    end else begin
      term_out_q <= term_out_d;
    end
  end

  assign TERMINAL_OUT = term_out_q;

  // ==========================================================
  // Interrupts: set wins over clear
  logic [4:0] irq_stat_q;
  logic [4:0] irq_stat_d;
  logic [4:0] irq_evt;

  always_comb begin
    irq_evt = 5'h00;
    irq_evt[outsig_pkg::IRQ_CAP]      = capacitor_wear_flag_q;
    irq_evt[outsig_pkg::IRQ_FAN]      = fan_wear_flag_q;
    irq_evt[outsig_pkg::IRQ_RXTO]     = rx_timeout_flag_q;
    irq_evt[outsig_pkg::IRQ_OVERTEMP] = heatsink_overtemp_flag_q;
    irq_evt[outsig_pkg::IRQ_STOP]     = run_stop_q;
    irq_stat_d = irq_stat_q;
    if (WR && ADDR == outsig_pkg::ADDR_IRQ_CLR) begin
      irq_stat_d = irq_stat_q & ~WDATA[4:0];
    end
    irq_stat_d = irq_stat_d | irq_evt;
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      irq_stat_q <= 5'h00;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  assign IRQ = |(irq_stat_q & irq_en_q);

  // ==========================================================
  // Read path, data one cycle after the strobe
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  always_comb begin
    int i;
    i = int'(ADDR[2:0]);
    rdata_d = 32'h0000_0000;
    if (RD) begin
      if (in_bank(ADDR, outsig_pkg::ADDR_OPND1_BASE))
        rdata_d[5:0] = opnd1_q[i];
      else if (in_bank(ADDR, outsig_pkg::ADDR_OPND2_BASE))
        rdata_d[5:0] = opnd2_q[i];
      else if (in_bank(ADDR, outsig_pkg::ADDR_OPER_BASE))
        rdata_d[1:0] = oper_q[i];
      else if (in_bank(ADDR, outsig_pkg::ADDR_TERM_BASE))
        rdata_d[5:0] = term_q[i];
      else begin
        case (ADDR)
          outsig_pkg::ADDR_RX_TIMEOUT: rdata_d[13:0] = rx_timeout_interval_q;
          outsig_pkg::ADDR_HS_WARN:    rdata_d[7:0] = heatsink_warning_level_q;
          outsig_pkg::ADDR_FAN_CTRL:   rdata_d[1:0] = fan_control_setting_q;
          outsig_pkg::ADDR_LINK_CFG:   rdata_d[1:0] = link_cfg_q;
          outsig_pkg::ADDR_LIFE_VIEW:
            rdata_d[1:0] = {fan_wear_flag_q, capacitor_wear_flag_q}; // R8
          outsig_pkg::ADDR_IRQ_STAT:   rdata_d[4:0] = irq_stat_q;
          outsig_pkg::ADDR_IRQ_EN:     rdata_d[4:0] = irq_en_q;
          outsig_pkg::ADDR_FLAGS:      rdata_d[11:0] = {comb_res, run_stop_q,
            rx_timeout_flag_q, heatsink_overtemp_flag_q,
            run_command_present_flag_q, fan_wear_flag_q,
            capacitor_wear_flag_q};
          default:                     rdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign RDATA = rdata_q;

endmodule

// file: core/outsig_pkg.sv
// Shared constants for the output-signal logic and status flag block.
// Assumes a single core clock at 20 MHz and a plain register port.
package outsig_pkg;

  // ==========================================================
  // Signal codes and block counts
  localparam logic [5:0]  CODE_MAX_OPND   = 6'h32;
  localparam logic [5:0]  CODE_LOG_FIRST  = 6'h21;
  localparam logic [5:0]  CODE_LOG_LAST   = 6'h26;
  localparam logic [5:0]  CODE_CAP_WEAR   = 6'h27;
  localparam logic [5:0]  CODE_FAN_WEAR   = 6'h28;
  localparam logic [5:0]  CODE_RUN_CMD    = 6'h29;
  localparam logic [5:0]  CODE_OVERTEMP   = 6'h2A;
  localparam logic [5:0]  CODE_NET_ERR    = 6'h1F;
  localparam int          COMB_COUNT      = 6;
  localparam int          TERM_COUNT      = 6;

  // ==========================================================
  // Operator codes
  localparam logic [1:0]  OP_AND          = 2'h0;
  localparam logic [1:0]  OP_OR           = 2'h1;
  localparam logic [1:0]  OP_XOR          = 2'h2;

  // ==========================================================
  // Register map, four banks of six words, then one word each
  localparam logic [7:0]  ADDR_OPND1_BASE = 8'h00;
  localparam logic [7:0]  ADDR_OPND2_BASE = 8'h08;
  localparam logic [7:0]  ADDR_OPER_BASE  = 8'h10;
  localparam logic [7:0]  ADDR_TERM_BASE  = 8'h18;
  localparam logic [7:0]  ADDR_RX_TIMEOUT = 8'h20;
  localparam logic [7:0]  ADDR_HS_WARN    = 8'h21;
  localparam logic [7:0]  ADDR_FAN_CTRL   = 8'h22;
  localparam logic [7:0]  ADDR_LINK_CFG   = 8'h23;
  localparam logic [7:0]  ADDR_LIFE_VIEW  = 8'h24;
  localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h25;
  localparam logic [7:0]  ADDR_IRQ_EN     = 8'h26;
  localparam logic [7:0]  ADDR_IRQ_CLR    = 8'h27;
  localparam logic [7:0]  ADDR_FLAGS      = 8'h28;

  // ==========================================================
  // Reset values, limits and setting codes
  localparam logic [5:0]  RST_OPND        = 6'h00;
  localparam logic [1:0]  RST_OPER        = 2'h0;
  localparam logic [5:0]  RST_TERM        = 6'h00;
  localparam logic [13:0] RST_RX_TIMEOUT  = 14'h0000;
  localparam logic [7:0]  RST_HS_WARN     = 8'h78;
  localparam logic [7:0]  HS_WARN_MAX     = 8'hC8;
  localparam logic [13:0] RX_TIMEOUT_MAX  = 14'h270F;
  localparam logic [1:0]  FAN_CTRL_QUIET  = 2'h1;
  localparam logic [1:0]  LINK_MODBUS     = 2'h1;
  localparam int          FAN_LOW_PCT     = 75;

  // ==========================================================
  // Timing: timeout unit is 10 ms, clock 20 MHz
  localparam int          CLK_HZ          = 20_000_000;
  localparam int          TICK_MS         = 10;
  localparam int          TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;

  // ==========================================================
  // Interrupt bit layout
  localparam int          IRQ_CAP         = 0;
  localparam int          IRQ_FAN         = 1;
  localparam int          IRQ_RXTO        = 2;
  localparam int          IRQ_OVERTEMP    = 3;
  localparam int          IRQ_STOP        = 4;

endpackage

// file: tb/output_signal_logic_props.sv
// Checker for the output-signal block, watching its top ports only.
// Assumes register writes land one cycle after the write strobe.
`timescale 1ns/10ps
module outsig_props (
  input wire logic        CORE_CLK,
  input wire logic        NRST,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic [63:0] SIG_IN,
  input wire logic        CAP_LIFE_LOW,
  input wire logic [7:0]  FAN_SPEED_PCT,
  input wire logic        FORWARD_COMMAND_INPUT,
  input wire logic        REVERSE_COMMAND_INPUT,
  input wire logic [7:0]  HEATSINK_TEMP,
  input wire logic [5:0]  TERMINAL_OUT,
  input wire logic        RUN_STOP
);
  logic [5:0] term_q [6];
  logic [7:0] warn_q;
  logic [1:0] fan_q, warm_q;
  // ==========================================================
  // Shadow settings; warm_q masks the first cycles
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      term_q <= '{default: 6'h00};
      warn_q <= 8'h78;
      fan_q  <= 2'h0;
      warm_q <= 2'h0;
    end else begin
      if (warm_q != 2'h3)
        warm_q <= warm_q + 2'h1;
      if (WR && ADDR >= 8'h18 && ADDR <= 8'h1D)
        term_q[ADDR[2:0]] <= WDATA[5:0];
      if (WR && ADDR == 8'h21 && WDATA <= 32'd200)
        warn_q <= WDATA[7:0];
      if (WR && ADDR == 8'h22)
        fan_q <= WDATA[1:0];
    end
  end
  // ==========================================================
  // Terminal routing held steady for three cycles
  default clocking dc @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  sequence s_steady(int i, logic [5:0] c);
    (warm_q == 2'h3 && !WR && term_q[i] == c) [*3];
  endsequence
  a_overtemp_term: assert property (s_steady(0, 6'h2A) |->
    TERMINAL_OUT[0] == $past(HEATSINK_TEMP > warn_q, 2))
    else $error("overtemp term");
  a_fan_term: assert property (s_steady(1, 6'h28) |->
    TERMINAL_OUT[1] == $past(FAN_SPEED_PCT <= 8'd75 && fan_q != 2'h1, 2))
    else $error("fan term");
  a_run_term: assert property (s_steady(2, 6'h29) |->
    TERMINAL_OUT[2] ==
    $past(FORWARD_COMMAND_INPUT ^ REVERSE_COMMAND_INPUT, 2))
    else $error("run term");
  a_cap_term: assert property (s_steady(3, 6'h27) |->
    TERMINAL_OUT[3] == $past(CAP_LIFE_LOW, 2))
    else $error("cap term");
  a_direct_term: assert property (s_steady(5, 6'h07) |->
    TERMINAL_OUT[5] == $past(SIG_IN[7]))
    else $error("direct term");
  a_stop_both: assert property (FORWARD_COMMAND_INPUT &&
    REVERSE_COMMAND_INPUT |=> RUN_STOP)
    else $error("stop missing");
  a_stop_clear: assert property (!(FORWARD_COMMAND_INPUT &&
    REVERSE_COMMAND_INPUT) |=> !RUN_STOP)
    else $error("stray stop");
  a_warn_read: assert property (RD && ADDR == 8'h21 |=>
    RDATA == {24'h0, $past(warn_q)})
    else $error("warn read");
  a_rdata_idle: assert property (!RD |=> RDATA == 32'h0)
    else $error("stray read data");
  a_unmapped_read: assert property (RD && ADDR > 8'h28 |=> RDATA == 32'h0)
    else $error("unmapped read");
endmodule

bind output_signal_logic outsig_props chk_u (.*);

// file: tb/output_signal_logic_tb_top.sv
// Self-checking bench for the output-signal block and its flags.
// Assumes the partner model drives run commands and serial strobes.
`timescale 1ns/10ps
module output_signal_logic_tb_top;
  localparam int TICK = 4;
  logic        core_clk, nrst, wr, rd, cap_low, fan_stop, fwd, rev;
  logic        rx_stb, run_stop, irq, allow_both, send_rx, fw, rv;
  logic [7:0]  addr, fan_pct, temp, tv, fv;
  logic [31:0] wdata, rdata, seed;
  logic [63:0] sig_in;
  logic [5:0]  term, ex;
  logic [1:0]  want;
  logic [5:0]  o1 [6], o2 [6];
  logic [1:0]  op [6];
  int          n_mismatch, num_checks;
  logic [5:0]  fcode [6] = '{6'h2A, 6'h28, 6'h29, 6'h27, 6'h1F, 6'h07};

  output_signal_logic #(.TICK_CYCLES(TICK)) dut_u (
    .CORE_CLK(core_clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .SIG_IN(sig_in),
    .CAP_LIFE_LOW(cap_low), .FAN_SPEED_PCT(fan_pct),
    .FAN_STOPPED(fan_stop), .FORWARD_COMMAND_INPUT(fwd),
    .REVERSE_COMMAND_INPUT(rev), .HEATSINK_TEMP(temp),
    .RX_DATA_STROBE(rx_stb), .TERMINAL_OUT(term),
    .RUN_STOP(run_stop), .IRQ(irq));
  outsig_partner ptr_u (.clk(core_clk), .rst_n(nrst), .want(want),
    .allow_both(allow_both), .send_rx(send_rx), .fwd(fwd), .rev(rev),
    .rx_stb(rx_stb));

  // ==========================================================
  // Helpers: random source, operator model, bus cycles
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic comb(input logic a, input logic b,
                                input logic [1:0] o);
    return (o == 2'h0) ? (a & b) : (o == 2'h1) ? (a | b) : (a ^ b);
  endfunction
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a, input logic [31:0] e,
                      input string what);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    @(negedge core_clk);
    chk(what, e, rdata);
  endtask
  task automatic probe(input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] e);
    wreg(a, d);
    rreg(a, e, "register");
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // Clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    n_mismatch++;
    close_out();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {nrst, addr, wdata, wr, rd, sig_in, cap_low} = '0;
    {fan_pct, fan_stop, temp, want, allow_both, send_rx} = '0;
    n_mismatch = 0;
    num_checks = 0;
    seed = 32'hb7f2_ad87;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    rreg(8'h21, 32'h0000_0078, "warn default");
    rreg(8'h00, 32'h0000_0000, "operand default");
    rreg(8'h10, 32'h0000_0000, "operator default");
    rreg(8'h20, 32'h0000_0000, "timeout default");
    rreg(8'h3F, 32'h0000_0000, "unmapped");
    probe(8'h21, 32'd201, 32'h0000_0078);
    probe(8'h21, 32'd200, 32'd200);
    probe(8'h00, 32'h0000_0021, 32'h0000_0000);
    probe(8'h05, 32'h0000_0026, 32'h0000_0000);
    probe(8'h00, 32'h0000_0033, 32'h0000_0000);
    probe(8'h00, 32'h0000_0032, 32'h0000_0032);
    probe(8'h10, 32'h0000_0003, 32'h0000_0000);
    probe(8'h20, 32'd10000, 32'h0000_0000);
    probe(8'h20, 32'd9999, 32'd9999);
    wreg(8'h21, 32'd120);
    $display("test registers done");
    for (int k = 0; k < 6; k++)
      wreg(8'h18 + k[7:0], 32'h21 + k);
    for (int t = 0; t < 12; t++) begin
      for (int k = 0; k < 6; k++) begin
        seed = lfsr(seed);
        o1[k] = (t == 0) ? 6'h32 : {1'b0, seed[4:0] % 5'd31};
        o2[k] = {1'b0, seed[12:8] % 5'd31};
        op[k] = 2'((t + k) % 3);
        wreg(8'h00 + k[7:0], {26'h0, o1[k]});
        wreg(8'h08 + k[7:0], {26'h0, o2[k]});
        wreg(8'h10 + k[7:0], {30'h0, op[k]});
      end
      seed = lfsr(seed);
      sig_in <= {seed, lfsr(seed)};
      settle(3);
      for (int k = 0; k < 6; k++)
        ex[k] = comb(sig_in[o1[k]], sig_in[o2[k]], op[k]);
      chk("combiners", 32'(ex), 32'(term));
    end
    $display("test combiners done");
    wreg(8'h20, 32'd5);
    for (int k = 0; k < 6; k++)
      wreg(8'h18 + k[7:0], {26'h0, fcode[k]});
    for (int i = 0; i < 40; i++) begin
      if (i == 20) begin
        wreg(8'h22, 32'h0000_0001);
      end
      @(posedge core_clk);
      seed = lfsr(seed);
      tv = (i == 0) ? 8'd120 : (i == 1) ? 8'd121 : seed[7:0];
      fv = (i == 0) ? 8'd75 : (i == 1) ? 8'd76 : seed[15:8];
      fw = seed[18];
      rv = seed[19] && !(seed[18] && !seed[20]);
      temp <= tv;
      fan_pct <= fv;
      cap_low <= seed[16];
      fan_stop <= seed[17];
      want <= seed[19:18];
      allow_both <= seed[20];
      sig_in <= {seed, seed};
      settle(4);
      ex = {seed[7], 1'b0, seed[16], fw ^ rv, fv <= 8'd75 && i < 20,
            tv > 8'd120};
      chk("flags", 32'(ex), 32'(term));
      chk("stop", 32'(fw & rv), 32'(run_stop));
      rreg(8'h24, {30'h0, ex[1], ex[3]}, "life view");
    end
    $display("test flags done");
    @(posedge core_clk);
    {temp, cap_low, want} <= '0;
    fan_pct <= 8'd100;
    settle(2);
    wreg(8'h27, 32'h0000_001F);
    wreg(8'h26, 32'h0000_0008);
    settle(3);
    chk("irq idle", 32'h0, 32'(irq));
    temp <= 8'd200;
    settle(3);
    temp <= 8'd0;
    settle(3);
    chk("irq sticky", 32'h1, 32'(irq));
    rreg(8'h25, 32'h0000_0008, "irq status");
    wreg(8'h27, 32'h0000_0008);
    settle(2);
    chk("irq cleared", 32'h0, 32'(irq));
    wreg(8'h26, 32'h0000_0000);
    temp <= 8'd200;
    settle(3);
    chk("irq masked", 32'h0, 32'(irq));
    $display("test interrupts done");
    wreg(8'h23, 32'h0000_0001);
    for (int w = 0; w < 60 && term[4] !== 1'b1; w++)
      settle(1);
    chk("timeout set", 32'h1, 32'(term[4]));
    settle(10);
    chk("timeout held", 32'h1, 32'(term[4]));
    send_rx <= 1'b1;
    @(posedge core_clk);
    send_rx <= 1'b0;
    settle(4);
    chk("timeout clear", 32'h0, 32'(term[4]));
    $display("test timeout done");
    close_out();
  end
endmodule

// file: tb/outsig_partner.sv
// Model of the outside controller: run commands and serial data strobes.
// Assumes bench requests are synchronous to the core clock.
`timescale 1ns/10ps
module outsig_partner (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] want,
  input  wire logic       allow_both,
  input  wire logic       send_rx,
  output logic            fwd,
  output logic            rev,
  output logic            rx_stb
);
  // ==========================================================
  // Both commands only when a scenario asks for the fault
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fwd    <= 1'b0;
      rev    <= 1'b0;
      rx_stb <= 1'b0;
    end else begin
      fwd    <= want[0];
      rev    <= want[1] && !(want[0] && !allow_both);
      rx_stb <= send_rx;
    end
  end
endmodule
